// ==== master_clock_select_control_test.sv ====
// Self-checking bench for the master clock select and control block
`include "mcs_cfg.svh"
module master_clock_select_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct {logic [4:0] div; int m; int c;} mcs_row_t;
  mcs_row_t rows [6] = '{'{5'h00, 128, 128}, '{5'h08, 64, 64}, '{5'h10, 32, 32},
    '{5'h18, 16, 16}, '{5'h03, 128, 16}, '{5'h07, 128, 1}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic flash_ws_option = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, master_tick, cpu_tick;
  logic flash_wait_state, switch_wake;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] periph_tick;
  logic [2:0] tick_cnt = 3'h0;
  mcs_pkg::mcs_osc_t osc_ready = 3'h1;
  mcs_pkg::mcs_osc_t osc_tick = 3'h0;
  mcs_pkg::mcs_osc_t osc_enable;
  mcs_pkg::mcs_mode_t mode = mcs_pkg::MCS_RUN;
  mcs_pkg::mcs_reg_t regulator;
  int bad_count = 0;
  int n_checks = 0;
  int m_cnt, c_cnt;
  int p_cnt [8];
  logic [7:0] sw_code [2] = '{8'hB4, 8'hE1};
  int sw_rate [2] = '{64, 128};
  logic [1:0] rm [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h0};
  logic [31:0] rp [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
  logic [31:0] rx [6] = '{32'h1, 32'h1, 32'h2, 32'h1, 32'h2, 32'h1};
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  // Fast RC every cycle, external every 2, slow RC every 8
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    osc_tick.fast_internal_rc <= 1'b1;
    osc_tick.slow_internal_rc <= (tick_cnt == 3'h7);
    osc_tick.fast_external_clock <= tick_cnt[0];
  end
  mcs_top dut_u (.clk(clk), .reset(reset), .ce(ce), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .osc_ready(osc_ready),
    .osc_tick(osc_tick), .mode(mode), .flash_ws_option(flash_ws_option),
    .osc_enable(osc_enable), .master_tick(master_tick), .cpu_tick(cpu_tick),
    .periph_tick(periph_tick), .regulator(regulator), .flash_wait_state(flash_wait_state),
    .switch_wake(switch_wake));
  ////////////////////////////////////////////////////////////////////////////////
  task chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task chk_cnt(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task end_test(input string s);
    $display("test %s done", s);
  endtask
  task settle;
    repeat (3) @(negedge clk);
  endtask
  // Each channel released only at the edge that takes it
  task axi_write(input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 50);
    bready <= 1'b0;
    rsp = bresp;
    if (t >= 50) chk_cnt("write answer", 0, t);
  endtask
  task axi_read(input logic [4:0] a);
    int t;
    t = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 50);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    if (t >= 50) chk_cnt("read answer", 0, t);
  endtask
  task wait_switch;
    int t;
    t = 0;
    do begin
      axi_read(`MCS_OFS_SW);
      t++;
    end while (rd[`MCS_SW_BUSY] !== 1'b0 && t < 20);
    if (t >= 20) chk_cnt("switch time", 0, t);
  endtask
  // Settle long enough for a full divide-by-128 group to pass
  task count_ticks(input int n);
    repeat (130) @(negedge clk);
    m_cnt = 0;
    c_cnt = 0;
    foreach (p_cnt[i]) p_cnt[i] = 0;
    repeat (n) begin
      @(negedge clk);
      m_cnt += (master_tick === 1'b1);
      c_cnt += (cpu_tick === 1'b1);
      for (int i = 0; i < 8; i++) p_cnt[i] += (periph_tick[i] === 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    axi_read(`MCS_OFS_CUR);
    chk_val("current", 32'hE1, rd);
    axi_read(`MCS_OFS_DIV);
    chk_val("divider", 32'h18, rd);
    chk_val("regulator", 32'h1, {30'h0, regulator});
    count_ticks(128);
    chk_cnt("master", 16, m_cnt);
    end_test("reset");
    foreach (rows[i]) begin
      axi_write(`MCS_OFS_DIV, {27'h0, rows[i].div});
      count_ticks(128);
      chk_cnt("master", rows[i].m, m_cnt);
      chk_cnt("cpu", rows[i].c, c_cnt);
      chk_cnt("periph0", rows[i].m, p_cnt[0]);
    end
    end_test("dividers");
    axi_write(`MCS_OFS_PCK, 32'h5A);
    count_ticks(128);
    for (int i = 0; i < 8; i++) begin
      chk_cnt("periph", ((32'h5A >> i) & 1) != 0 ? 128 : 0, p_cnt[i]);
    end
    end_test("gating");
    axi_write(`MCS_OFS_DIV, 32'h0);
    axi_write(`MCS_OFS_SW, 32'h2);
    axi_write(`MCS_OFS_TGT, 32'hD2);
    axi_read(`MCS_OFS_CUR);
    chk_val("current busy", 32'hE1, rd);
    axi_read(`MCS_OFS_SW);
    chk_val("switch busy", 32'h6, rd);
    axi_write(`MCS_OFS_OSC, 32'h0);
    axi_read(`MCS_OFS_OSC);
    chk_val("fast rc kept", 32'h1, rd & 32'h1);
    settle;
    chk_val("osc_enable busy", 32'h3, {29'h0, osc_enable});
    @(posedge clk) osc_ready <= 3'h3;
    wait_switch;
    axi_read(`MCS_OFS_CUR);
    chk_val("current", 32'hD2, rd);
    axi_read(`MCS_OFS_SW);
    chk_val("switch done", 32'h3, rd);
    settle;
    chk_val("wake", 32'h1, {31'h0, switch_wake});
    count_ticks(128);
    chk_cnt("master slow", 16, m_cnt);
    axi_write(`MCS_OFS_SW, 32'h3);
    settle;
    chk_val("wake cleared", 32'h0, {31'h0, switch_wake});
    axi_write(`MCS_OFS_OSC, 32'h2);
    settle;
    chk_val("osc_enable", 32'h2, {29'h0, osc_enable});
    end_test("slow switch");
    axi_write(`MCS_OFS_TGT, 32'h55);
    axi_read(`MCS_OFS_SW);
    chk_val("no switch", 32'h2, rd & 32'h6);
    axi_read(`MCS_OFS_CUR);
    chk_val("current kept", 32'hD2, rd);
    count_ticks(128);
    chk_cnt("master kept", 16, m_cnt);
    end_test("undefined code");
    @(posedge clk) osc_ready <= 3'h7;
    for (int i = 0; i < 2; i++) begin
      axi_write(`MCS_OFS_TGT, {24'h0, sw_code[i]});
      wait_switch;
      axi_read(`MCS_OFS_CUR);
      chk_val("current", {24'h0, sw_code[i]}, rd);
      count_ticks(128);
      chk_cnt("master", sw_rate[i], m_cnt);
    end
    axi_write(`MCS_OFS_CUR, 32'hD2);
    axi_read(`MCS_OFS_CUR);
    chk_val("current read-only", 32'hE1, rd);
    axi_read(5'h1C);
    chk_val("unmapped resp", 32'h2, {30'h0, rsp});
    chk_val("unmapped data", 32'h0, rd);
    end_test("external");
    for (int i = 0; i < 6; i++) begin
      axi_write(`MCS_OFS_PWR, rp[i]);
      @(posedge clk) mode <= mcs_pkg::mcs_mode_t'(rm[i]);
      settle;
      chk_val("regulator", rx[i], {30'h0, regulator});
    end
    end_test("regulator");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) flash_ws_option <= (i == 1);
      settle;
      chk_val("flash ws", i, {31'h0, flash_wait_state});
    end
    end_test("flash");
    // Clock enable low freezes the regulator choice and the bus
    @(posedge clk) ce <= 1'b0;
    mode <= mcs_pkg::MCS_HALT;
    settle;
    chk_val("frozen awready", 32'h0, {31'h0, awready});
    chk_val("frozen regulator", 32'h1, {30'h0, regulator});
    @(posedge clk) ce <= 1'b1;
    settle;
    chk_val("regulator", 32'h2, {30'h0, regulator});
    @(posedge clk) mode <= mcs_pkg::MCS_RUN;
    end_test("clock enable");
    // Second reset taken while running from the slow RC
    axi_write(`MCS_OFS_TGT, 32'hD2);
    wait_switch;
    axi_read(`MCS_OFS_CUR);
    chk_val("current before reset", 32'hD2, rd);
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    axi_read(`MCS_OFS_CUR);
    chk_val("current", 32'hE1, rd);
    chk_val("osc_enable", 32'h1, {29'h0, osc_enable});
    count_ticks(128);
    chk_cnt("master", 16, m_cnt);
    end_test("second reset");
    test_done;
  end
endmodule // master_clock_select_control_test

// ==== mcs_cfg.svh ====
// Constants for the master clock select and control block
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH
`define MCS_OFS_CUR 5'h00
`define MCS_OFS_TGT 5'h04
`define MCS_OFS_DIV 5'h08
`define MCS_OFS_SW 5'h0C
`define MCS_OFS_OSC 5'h10
`define MCS_OFS_PCK 5'h14
`define MCS_OFS_PWR 5'h18
`define MCS_CODE_HSI 8'hE1
`define MCS_CODE_LSI 8'hD2
`define MCS_CODE_HSE 8'hB4
`define MCS_RST_FAST_RC_PRESCALER 2'h3
`define MCS_RST_CPU_CLOCK_DIVIDER 3'h0
`define MCS_RST_OSC 3'h1
`define MCS_SW_FLAG 0
`define MCS_SW_IEN 1
`define MCS_SW_BUSY 2
`define MCS_PWR_AHLP 0
`define MCS_REG_MAIN 2'h1
`define MCS_REG_LP 2'h2
`define MCS_RESP_OK 2'h0
`define MCS_RESP_ERR 2'h2
`endif

// ==== mcs_pkg.sv ====
// Types for the master clock select and control block
package mcs_pkg;
  // Oscillator vector: bit 0 fast RC, bit 1 slow RC, bit 2 external
  typedef struct packed {
    logic fast_external_clock;
    logic slow_internal_rc;
    logic fast_internal_rc;
  } mcs_osc_t;
  typedef struct packed {
    logic [1:0] hsi_div;
    logic [2:0] cpu_div;
  } mcs_div_t;
  typedef enum logic [1:0] {
    MCS_RUN = 2'h0,
    MCS_WAIT = 2'h1,
    MCS_AHALT = 2'h2,
    MCS_HALT = 2'h3
  } mcs_mode_t;
  typedef enum logic [1:0] {
    MCS_SW_IDLE = 2'h1,
    MCS_SW_WAIT = 2'h2
  } mcs_sw_state_t;
  // Regulator select: main and low-power are never both on
  typedef struct packed {
    logic low_power_regulator;
    logic main_regulator;
  } mcs_reg_t;
endpackage

// ==== mcs_tick_div.sv ====
// Power-of-two divider of a clock-enable pulse train
`include "mcs_cfg.svh"
module mcs_tick_div #(
  parameter int SW = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic tick_in,
  input wire logic [SW-1:0] sel,
  output logic tick_out
);
  localparam int CW = (1 << SW) - 1;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] mask;
  logic tick_r;

  initial begin
    if (SW < 1 || SW > 3) $error("mcs_tick_div: SW must be 1 to 3");
  end

  assign mask = CW'((1 << sel) - 1);
  assign tick_out = tick_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (ce && tick_in) begin
      cnt_r <= ((cnt_r & mask) == mask) ? '0 : cnt_r + 1'b1;
    end
  end

  // Out pulse on the last input pulse of each group of 2^sel
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= tick_in && ((cnt_r & mask) == mask);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  div_one_a: assert property (ce && tick_in && sel == '0 |=> tick_r)
    else $error("undivided pulse lost");
  div_gap_a: assert property (ce && sel != '0 && tick_r |=> !tick_r)
    else $error("divided pulses back to back");
endmodule // mcs_tick_div

// ==== mcs_top.sv ====
// Master clock select, dividers, gating and regulator choice
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`include "mcs_cfg.svh"
module mcs_top #(
  parameter int NPER = 8,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire mcs_pkg::mcs_osc_t osc_ready,
  input wire mcs_pkg::mcs_osc_t osc_tick,
  input wire mcs_pkg::mcs_mode_t mode,
  input wire logic flash_ws_option,
  output mcs_pkg::mcs_osc_t osc_enable,
  output logic master_tick,
  output logic cpu_tick,
  output logic [NPER-1:0] periph_tick,
  output mcs_pkg::mcs_reg_t regulator,
  output logic flash_wait_state,
  output logic switch_wake
);
  initial begin
    if (NPER < 1 || NPER > 8) $error("mcs_top: NPER must be 1 to 8");
    if (AW < 5) $error("mcs_top: AW must be at least 5");
  end

  logic [AW-1:0] aw_addr_r;
  logic aw_full_r;
  logic [7:0] w_data_r;
  logic w_strb_r;
  logic w_full_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_wr;
  logic do_rd;
  logic [7:0] cur_r;
  logic [7:0] tgt_r;
  mcs_pkg::mcs_div_t div_r;
  logic flag_r;
  logic ien_r;
  mcs_pkg::mcs_osc_t osc_en_r;
  mcs_pkg::mcs_osc_t osc_out_r;
  logic [NPER-1:0] pck_r;
  logic ahlp_r;
  mcs_pkg::mcs_sw_state_t st_r;
  mcs_pkg::mcs_osc_t cur_mask;
  mcs_pkg::mcs_osc_t tgt_mask;
  logic sw_done;
  logic wr_tgt;
  logic wr_sw;
  logic master_nxt;
  logic hsi_div_tick;
  logic master_r;
  logic [NPER-1:0] pck_tick_r;
  mcs_pkg::mcs_reg_t reg_r;
  logic fws_r;
  logic wake_r;

  function automatic mcs_pkg::mcs_osc_t src_mask(input logic [7:0] code);
    mcs_pkg::mcs_osc_t m;
    m = '0;
    unique case (code)
      `MCS_CODE_HSI: m.fast_internal_rc = 1'b1;
      `MCS_CODE_LSI: m.slow_internal_rc = 1'b1;
      `MCS_CODE_HSE: m.fast_external_clock = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return a == `MCS_OFS_CUR || a == `MCS_OFS_TGT || a == `MCS_OFS_DIV ||
      a == `MCS_OFS_SW || a == `MCS_OFS_OSC || a == `MCS_OFS_PCK || a == `MCS_OFS_PWR;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave

  assign s_axi_awready = ce && !aw_full_r && !bvalid_r;
  assign s_axi_wready = ce && !w_full_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign do_wr = ce && aw_full_r && w_full_r && !bvalid_r;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  // Only lane 0 carries register bits; upper lanes are ignored
  assign wr_tgt = do_wr && w_strb_r && aw_addr_r == `MCS_OFS_TGT;
  assign wr_sw = do_wr && w_strb_r && aw_addr_r == `MCS_OFS_SW;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_full_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= `MCS_RESP_OK;
    end else if (ce) begin
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(aw_addr_r) ? `MCS_RESP_OK : `MCS_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `MCS_RESP_OK;
    end else if (ce) begin
      if (do_rd) begin
        rvalid_r <= 1'b1;
        rresp_r <= mapped(s_axi_araddr) ? `MCS_RESP_OK : `MCS_RESP_ERR;
        unique case (s_axi_araddr)
          `MCS_OFS_CUR: rdata_r <= {24'h000000, cur_r};
          `MCS_OFS_TGT: rdata_r <= {24'h000000, tgt_r};
          `MCS_OFS_DIV: rdata_r <= {27'h0000000, div_r};
          `MCS_OFS_SW: rdata_r <= {29'h00000000, st_r == mcs_pkg::MCS_SW_WAIT, ien_r, flag_r};
          `MCS_OFS_OSC: rdata_r <= {29'h00000000, osc_out_r};
          `MCS_OFS_PCK: rdata_r <= {{(32 - NPER){1'b0}}, pck_r};
          `MCS_OFS_PWR: rdata_r <= {31'h00000000, ahlp_r};
          default: rdata_r <= '0;
        endcase
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk) begin
    if (reset) begin
      tgt_r <= `MCS_CODE_HSI;
      div_r <= {`MCS_RST_FAST_RC_PRESCALER, `MCS_RST_CPU_CLOCK_DIVIDER};
      pck_r <= '1;
      ahlp_r <= 1'b0;
      ien_r <= 1'b0;
    end else if (do_wr && w_strb_r) begin
      unique case (aw_addr_r)
        `MCS_OFS_TGT: tgt_r <= w_data_r;
        `MCS_OFS_DIV: div_r <= w_data_r[4:0];
        `MCS_OFS_PCK: pck_r <= w_data_r[NPER-1:0];
        `MCS_OFS_PWR: ahlp_r <= w_data_r[`MCS_PWR_AHLP];
        `MCS_OFS_SW: ien_r <= w_data_r[`MCS_SW_IEN];
        default: ;
      endcase
    end
  end

  // Enables of the running source cannot be cleared by software
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_en_r <= `MCS_RST_OSC;
    end else if (do_wr && w_strb_r && aw_addr_r == `MCS_OFS_OSC) begin
      osc_en_r <= w_data_r[2:0] | cur_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencer

  assign cur_mask = src_mask(cur_r);
  assign tgt_mask = src_mask(tgt_r);
  assign sw_done = st_r == mcs_pkg::MCS_SW_WAIT && (osc_ready & tgt_mask) != '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= mcs_pkg::MCS_SW_IDLE;
    end else if (ce) begin
      unique case (st_r)
        mcs_pkg::MCS_SW_IDLE: begin
          if (tgt_mask != '0 && tgt_r != cur_r) begin
            st_r <= mcs_pkg::MCS_SW_WAIT;
          end
        end
        mcs_pkg::MCS_SW_WAIT: begin
          if (sw_done || tgt_mask == '0 || tgt_r == cur_r) begin
            st_r <= mcs_pkg::MCS_SW_IDLE;
          end
        end
        default: st_r <= mcs_pkg::MCS_SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur_r <= `MCS_CODE_HSI;
    end else if (ce && sw_done) begin
      cur_r <= tgt_r;
    end
  end

  // A completing switch wins over a clearing write
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      if (sw_done) begin
        flag_r <= 1'b1;
      end else if (wr_sw && w_data_r[`MCS_SW_FLAG]) begin
        flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_out_r <= `MCS_RST_OSC;
      wake_r <= 1'b0;
    end else if (ce) begin
      osc_out_r <= osc_en_r | cur_mask | (st_r == mcs_pkg::MCS_SW_WAIT ? tgt_mask : 3'h0);
      wake_r <= flag_r && ien_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock trees

  mcs_tick_div #(.SW(2)) u_hsi_div (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .tick_in(osc_tick.fast_internal_rc),
    .sel(div_r.hsi_div),
    .tick_out(hsi_div_tick)
  );

  assign master_nxt = cur_mask.fast_internal_rc ? hsi_div_tick : cur_mask.slow_internal_rc ? osc_tick.slow_internal_rc :
    osc_tick.fast_external_clock;

  // CPU divider sits after the master tick, so peripherals keep full rate
  mcs_tick_div #(.SW(3)) u_cpu_div (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .tick_in(master_r),
    .sel(div_r.cpu_div),
    .tick_out(cpu_tick)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      master_r <= 1'b0;
    end else if (ce) begin
      master_r <= master_nxt;
    end
  end

  for (genvar i = 0; i < NPER; i++) begin : g_pck
    always_ff @(posedge clk) begin
      if (reset) begin
        pck_tick_r[i] <= 1'b0;
      end else if (ce) begin
        pck_tick_r[i] <= master_nxt && pck_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator and flash wait state

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_r <= `MCS_REG_MAIN;
      fws_r <= 1'b0;
    end else if (ce) begin
      unique case (mode)
        mcs_pkg::MCS_HALT: reg_r <= `MCS_REG_LP;
        mcs_pkg::MCS_AHALT: reg_r <= ahlp_r ? `MCS_REG_LP : `MCS_REG_MAIN;
        default: reg_r <= `MCS_REG_MAIN;
      endcase
      fws_r <= flash_ws_option;
    end
  end

  assign osc_enable = osc_out_r;
  assign master_tick = master_r;
  assign periph_tick = pck_tick_r;
  assign regulator = reg_r;
  assign flash_wait_state = fws_r;
  assign switch_wake = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rst_source_a: assert property ($past(reset) |-> cur_r == `MCS_CODE_HSI)
    else $error("current source not fast RC after reset");
  rst_prescale_a: assert property ($past(reset) |-> div_r.hsi_div == `MCS_RST_FAST_RC_PRESCALER)
    else $error("prescaler not divide by eight after reset");
  bad_code_a: assert property (ce && tgt_mask == '0 && st_r == mcs_pkg::MCS_SW_IDLE
    |=> $stable(cur_r) && st_r == mcs_pkg::MCS_SW_IDLE)
    else $error("undefined code started a switch");
  cur_copy_a: assert property (!$stable(cur_r) |-> cur_r == $past(tgt_r) && flag_r)
    else $error("current source changed without completed switch");
  keep_source_a: assert property (ce
    |=> (osc_enable & $past(cur_mask)) == $past(cur_mask))
    else $error("running source enable cleared");
  run_main_a: assert property (ce && (mode == mcs_pkg::MCS_RUN || mode == mcs_pkg::MCS_WAIT)
    |=> regulator == `MCS_REG_MAIN)
    else $error("low-power regulator used in run or wait");
  halt_lp_a: assert property (ce && mode == mcs_pkg::MCS_HALT |=> regulator == `MCS_REG_LP)
    else $error("main regulator used in halt");
  ahalt_sel_a: assert property (ce && mode == mcs_pkg::MCS_AHALT
    |=> regulator.low_power_regulator == $past(ahlp_r))
    else $error("active halt regulator not as selected");
  wake_a: assert property (ce && flag_r && ien_r |=> switch_wake)
    else $error("switch completion did not wake");
  gate_off_a: assert property (ce && !pck_r[0] |=> !periph_tick[0])
    else $error("gated peripheral still ticks");
  flash_ws_a: assert property (ce && flash_ws_option |=> flash_wait_state)
    else $error("wait state not added");
  sw_lsi_c: cover property (sw_done && tgt_mask.slow_internal_rc);
  sw_hse_c: cover property (sw_done && tgt_mask.fast_external_clock);
  bad_code_c: cover property (wr_tgt && src_mask(w_data_r) == '0);
  flag_race_c: cover property (sw_done && wr_sw && w_data_r[`MCS_SW_FLAG]);
endmodule // mcs_top
